// file: include/udtc_pkg.sv
// udtc_pkg: constants and carrier types for the up/down timer compare core.
// assumes a 16-bit register port with word indices, one core clock.
package udtc_pkg;

    // ****************************************************************
    // register indices
    // ****************************************************************
    localparam logic [3:0] ADDR_CTRL  = 4'h0;
    localparam logic [3:0] ADDR_MAX   = 4'h1;
    localparam logic [3:0] ADDR_COUNT = 4'h2;
    localparam logic [3:0] ADDR_STAT  = 4'h3;
    localparam logic [3:0] ADDR_CCCTL0 = 4'h4;
    localparam logic [3:0] ADDR_CCCTL1 = 4'h5;
    localparam logic [3:0] ADDR_CCR0  = 4'h6;
    localparam logic [3:0] ADDR_CCR1  = 4'h7;
    localparam logic [3:0] ADDR_FLAG  = 4'h8;
    localparam logic [3:0] ADDR_ENA   = 4'h9;

    // ****************************************************************
    // field positions and counts
    // ****************************************************************
    localparam int CTRL_SINGLE = 2;
    localparam int CTRL_PRESET = 3;
    localparam int CTRL_RUN    = 4;
    localparam int CTRL_PEND   = 5;
    localparam int STAT_BUSY   = 0;
    localparam int STAT_UP     = 1;
    localparam int CC_MODE     = 0;
    localparam int FLG_MAX     = 0;
    localparam int FLG_ZERO    = 1;
    localparam int FLG_CC0     = 2;
    localparam int NUM_CC      = 2;
    localparam int NUM_FLG     = 4;

    // ****************************************************************
    // reset values and shared constants
    // ****************************************************************
    localparam logic [15:0] RST_MAX   = 16'hFFFF;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [15:0] RST_CCR   = 16'h0000;
    localparam logic [15:0] ZERO16    = 16'h0000;
    localparam logic [15:0] ONE16     = 16'h0001;

    // ****************************************************************
    // modes
    // ****************************************************************
    typedef enum logic [1:0] {
        UDTC_DIR_UP   = 2'b00,
        UDTC_DIR_DOWN = 2'b01,
        UDTC_DIR_UPDN = 2'b10,
        UDTC_DIR_RSVD = 2'b11
    } udtc_dir_t;

    localparam logic [2:0] BUF_IMMED = 3'h0;
    localparam logic [2:0] BUF_ZERO  = 3'h1;
    localparam logic [2:0] BUF_MAX   = 3'h2;
    localparam logic [2:0] BUF_BOTH  = 3'h3;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [15:0] wdata;
    } udtc_req_t;

    typedef struct packed {
        logic [2:0] sync;
        udtc_dir_t  dirsel;
        logic       single_pass_sel;
        logic       run;
        logic       pend;
        logic       up;
        logic [15:0] cnt;
        logic [15:0] max_count_field;
        logic [15:0] emax;
        logic [NUM_CC-1:0]       ccmode;
        logic [NUM_CC-1:0][2:0]  bufmd;
        logic [NUM_CC-1:0][15:0] ccr;
        logic [NUM_CC-1:0][15:0] cbuf;
        logic [NUM_FLG-1:0] flags;
        logic [NUM_FLG-1:0] inten;
        logic [NUM_FLG-1:0] evt;
        logic [NUM_CC-1:0]  match;
        logic [15:0] rdata;
    } udtc_state_t;

endpackage

// file: rtl/udtc_core.sv
// udtc_core: one 16-bit up/down timer channel with two compare circuits.
// assumes count_clock is a slow external pin, synchronised here, and a
// register master on core_clk that never issues read and write together.
`timescale 1ns/100ps
module udtc_core (
    input  wire logic                      core_clk,
    input  wire logic                      rst_n,
    input  wire udtc_pkg::udtc_req_t       req,
    output logic [15:0]                    rd_data,
    input  wire logic                      count_clock,
    output logic [udtc_pkg::NUM_CC-1:0]    cc_match,
    output logic [udtc_pkg::NUM_FLG-1:0]   evt_req,
    output logic                           running_status
);
    import udtc_pkg::*;

    // ****************************************************************
    // buffer load decision
    // ****************************************************************
    function automatic logic buf_load(
        input logic [2:0] md,
        input logic       at_zero,
        input logic       at_max
    );
        logic ld;
        ld = 1'b0;
        case (md)
            BUF_ZERO: ld = at_zero;
            BUF_MAX:  ld = at_max;
            BUF_BOTH: ld = at_zero | at_max;
            default:  ld = 1'b1;
        endcase
        return ld;
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    udtc_state_t        r;
    udtc_state_t        next_r;
    logic               tick;
    logic               preset;
    logic               stepped;
    logic [15:0]        nc;
    logic               cmp_on;
    logic [NUM_FLG-1:0] setf;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        next_r = r;
        next_r.sync = {r.sync[1:0], count_clock};
        next_r.match = '0;
        next_r.rdata = ZERO16;
        tick = r.sync[1] & ~r.sync[2];
        preset = 1'b0;
        stepped = 1'b0;
        nc = r.cnt;
        setf = '0;
        cmp_on = ~&r.ccmode;

        // register reads
        if (req.rd) begin
            case (req.addr)
                ADDR_CTRL: begin
                    next_r.rdata[1:0] = r.dirsel;
                    next_r.rdata[CTRL_SINGLE] = r.single_pass_sel;
                    next_r.rdata[CTRL_RUN] = r.run;
                    next_r.rdata[CTRL_PEND] = r.pend;
                end
                ADDR_MAX: next_r.rdata = r.max_count_field;
                ADDR_COUNT: next_r.rdata = r.cnt;
                ADDR_STAT: begin
                    next_r.rdata[STAT_BUSY] = r.run;
                    next_r.rdata[STAT_UP] = r.up;
                end
                ADDR_CCCTL0: next_r.rdata[3:0] = {r.bufmd[0], r.ccmode[0]};
                ADDR_CCCTL1: next_r.rdata[3:0] = {r.bufmd[1], r.ccmode[1]};
                ADDR_CCR0: next_r.rdata = r.ccr[0];
                ADDR_CCR1: next_r.rdata = r.ccr[1];
                ADDR_FLAG: next_r.rdata[NUM_FLG-1:0] = r.flags;
                ADDR_ENA: next_r.rdata[NUM_FLG-1:0] = r.inten;
                default: next_r.rdata = ZERO16;
            endcase
        end

        // register writes
        if (req.wr) begin
            case (req.addr)
                ADDR_CTRL: begin
                    next_r.dirsel = udtc_dir_t'(req.wdata[1:0]);
                    next_r.single_pass_sel = req.wdata[CTRL_SINGLE];
                    next_r.run = req.wdata[CTRL_RUN];
                    preset = req.wdata[CTRL_PRESET];
                end
                ADDR_MAX: begin
                    next_r.max_count_field = req.wdata;
                    next_r.pend = 1'b1;
                end
                ADDR_CCCTL0: begin
                    next_r.ccmode[0] = req.wdata[CC_MODE];
                    next_r.bufmd[0] = req.wdata[3:1];
                end
                ADDR_CCCTL1: begin
                    next_r.ccmode[1] = req.wdata[CC_MODE];
                    next_r.bufmd[1] = req.wdata[3:1];
                end
                ADDR_CCR0: next_r.ccr[0] = req.wdata;
                ADDR_CCR1: next_r.ccr[1] = req.wdata;
                ADDR_FLAG: next_r.flags = r.flags & ~req.wdata[NUM_FLG-1:0];
                ADDR_ENA: next_r.inten = req.wdata[NUM_FLG-1:0];
                default: begin
                end
            endcase
        end

        // ************************************************************
        // counter
        // ************************************************************
        if (preset) begin
            // preset consumes any pending max at once
            next_r.emax = next_r.max_count_field;
            next_r.pend = 1'b0;
            if (next_r.dirsel == UDTC_DIR_DOWN) begin
                next_r.cnt = next_r.max_count_field;
                next_r.up = 1'b0;
            end else begin
                next_r.cnt = ZERO16;
                next_r.up = 1'b1;
            end
        end else if (tick && r.run) begin
            stepped = 1'b1;
            case (r.dirsel)
                UDTC_DIR_UP: begin
                    next_r.up = 1'b1;
                    next_r.emax = r.max_count_field;
                    next_r.pend = 1'b0;
                    if (r.cnt >= r.max_count_field) begin
                        nc = ZERO16;
                        if (r.single_pass_sel) begin
                            next_r.run = 1'b0;
                        end
                    end else begin
                        nc = r.cnt + ONE16;
                    end
                end
                UDTC_DIR_DOWN: begin
                    next_r.up = 1'b0;
                    if (r.cnt == ZERO16) begin
                        nc = r.max_count_field;
                        next_r.emax = r.max_count_field;
                        next_r.pend = 1'b0;
                        if (r.single_pass_sel) begin
                            next_r.run = 1'b0;
                        end
                    end else begin
                        nc = r.cnt - ONE16;
                    end
                end
                UDTC_DIR_UPDN: begin
                    if (r.up) begin
                        next_r.emax = r.max_count_field;
                        next_r.pend = 1'b0;
                        if (r.cnt > r.max_count_field) begin
                            nc = ZERO16;
                        end else if (r.cnt == r.max_count_field) begin
                            next_r.up = 1'b0;
                            nc = (r.cnt == ZERO16) ? ZERO16 : r.cnt - ONE16;
                        end else begin
                            nc = r.cnt + ONE16;
                        end
                    end else if (r.cnt == ZERO16) begin
                        next_r.up = 1'b1;
                        next_r.emax = r.max_count_field;
                        next_r.pend = 1'b0;
                        nc = (r.max_count_field == ZERO16) ? ZERO16 : ONE16;
                    end else begin
                        nc = r.cnt - ONE16;
                        if (r.single_pass_sel && nc == ZERO16) begin
                            next_r.run = 1'b0;
                        end
                    end
                end
                default: begin
                    // hold mode: no step, so no events either
                    stepped = 1'b0;
                end
            endcase
            next_r.cnt = nc;
        end

        // a max write in this cycle stays pending
        if (req.wr && req.addr == ADDR_MAX) begin
            next_r.pend = 1'b1;
        end

        // ************************************************************
        // compare and events
        // ************************************************************
        if (stepped && cmp_on) begin
            setf[FLG_MAX] = (nc == next_r.emax);
            setf[FLG_ZERO] = (nc == ZERO16);
        end
        for (int i = 0; i < NUM_CC; i++) begin
            if (buf_load(r.bufmd[i], stepped && nc == ZERO16, stepped && nc == next_r.emax)) begin
                next_r.cbuf[i] = r.ccr[i];
            end
            if (stepped && !r.ccmode[i] && nc == r.cbuf[i]) begin
                next_r.match[i] = 1'b1;
                setf[FLG_CC0 + i] = 1'b1;
            end
        end
        next_r.flags = next_r.flags | setf;
        next_r.evt = next_r.flags & next_r.inten;
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            r <= '0;
            r.dirsel <= UDTC_DIR_UP;
            r.up <= 1'b1;
            r.cnt <= RST_COUNT;
            r.max_count_field <= RST_MAX;
            r.emax <= RST_MAX;
            r.ccr <= {NUM_CC{RST_CCR}};
            r.cbuf <= {NUM_CC{RST_CCR}};
        end else begin
            r <= next_r;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign rd_data = r.rdata;
    assign cc_match = r.match;
    assign evt_req = r.evt;
    assign running_status = r.run;

endmodule

// file: testbench/udtc_core_checker.sv
// udtc_core_checker: port-level assertions for the up/down timer compare core.
// assumes it is bound to udtc_core and sees only that module's ports.
`timescale 1ns/100ps
module udtc_core_checker (
    input wire logic                    core_clk,
    input wire logic                    rst_n,
    input wire udtc_pkg::udtc_req_t     req,
    input wire logic [15:0]             rd_data,
    input wire logic                    count_clock,
    input wire logic [1:0]              cc_match,
    input wire logic [3:0]              evt_req,
    input wire logic                    running_status
);
    import udtc_pkg::*;
    // ****************************************************************
    // helpers and assertions
    // ****************************************************************
    logic [7:0] hist;
    wire        step_seen = |(hist[6:0] & ~hist[7:1]);
    wire        ctrl_w    = req.wr && (req.addr == ADDR_CTRL);
    wire        ena_w     = req.wr && (req.addr == ADDR_ENA);
    always_ff @(posedge core_clk) begin
        hist <= {hist[6:0], count_clock};
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_rdata_idle: assert property (
        !$past(req.rd) |-> rd_data == 16'h0000) else $error("read data outside read answer");
    a_stat_busy: assert property (
        req.rd && req.addr == ADDR_STAT |=> rd_data[STAT_BUSY] == $past(running_status))
        else $error("status busy bit differs from running status");
    a_run_start: assert property (
        ctrl_w && req.wdata[CTRL_RUN] && !req.wdata[CTRL_SINGLE] && req.wdata[1:0] != 2'b11
        |=> running_status) else $error("run write did not start counter");
    a_run_cause: assert property (
        $rose(running_status) |-> $past(ctrl_w && req.wdata[CTRL_RUN])) else $error("start without run write");
    a_run_stop: assert property (
        ctrl_w && !req.wdata[CTRL_RUN] |=> !running_status) else $error("run clear did not stop");
    a_stop_cause: assert property (
        $fell(running_status) |-> $past(ctrl_w) || step_seen) else $error("stop without cause");
    a_match_pulse: assert property (
        cc_match != 2'b00 |=> cc_match == 2'b00) else $error("match longer than one cycle");
    a_match_cause: assert property (
        cc_match != 2'b00 |-> step_seen) else $error("match without count step");
    a_flag_clear: assert property (
        ($stable(count_clock))[*5] ##0 (req.wr && req.addr == ADDR_FLAG && req.wdata[3:0] == 4'hF)
        |-> ##2 evt_req == 4'h0) else $error("flags not cleared by write one");
    a_evt_cause: assert property (
        $rose(evt_req[0]) |-> $past(ena_w) || $past(ena_w, 2) || step_seen) else $error("event without cause");
    c_run: cover property (ctrl_w && req.wdata[CTRL_RUN]);
    c_auto_stop: cover property ($fell(running_status) && !$past(ctrl_w));
    c_match: cover property (cc_match[0]);
endmodule

bind udtc_core udtc_core_checker chk (.core_clk(core_clk), .rst_n(rst_n), .req(req), .rd_data(rd_data),
    .count_clock(count_clock), .cc_match(cc_match), .evt_req(evt_req), .running_status(running_status));

// file: testbench/udtc_core_tb.sv
// udtc_core_tb: self-checking bench for the up/down timer compare core.
// assumes udtc_pkg compiled first and the checker bound to the core.
`timescale 1ns/100ps
module udtc_core_tb;
    import udtc_pkg::*;
    // ****************************************************************
    // harness
    // ****************************************************************
    logic        core_clk;
    logic        rst_n;
    logic        count_clock;
    udtc_req_t   req;
    logic [15:0] rd_data;
    logic [1:0]  cc_match;
    logic [3:0]  evt_req;
    logic        running_status;
    int          fail_count = 0;
    int          checks_done = 0;
    udtc_core dut (.core_clk(core_clk), .rst_n(rst_n), .req(req), .rd_data(rd_data), .count_clock(count_clock),
        .cc_match(cc_match), .evt_req(evt_req), .running_status(running_status));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic conclude();
        if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge core_clk);
        req <= '0;
        @(posedge core_clk);
    endtask
    task automatic bus_rd(input logic [3:0] a, input logic [15:0] exp);
        req <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge core_clk);
        req <= '0;
        #1 check(rd_data, exp);
        @(posedge core_clk);
    endtask
    task automatic pulse();
        count_clock <= 1'b1;
        repeat (3) @(posedge core_clk);
        count_clock <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask
    task automatic step_match(input logic [1:0] exp);
        count_clock <= 1'b1;
        repeat (3) @(posedge core_clk);
        count_clock <= 1'b0;
        #1 check({14'h0, cc_match}, {14'h0, exp});
        repeat (2) @(posedge core_clk);
    endtask
    task automatic walk(input logic [15:0] exp [$]);
        foreach (exp[i]) begin
            pulse();
            bus_rd(ADDR_COUNT, exp[i]);
        end
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset();
        bus_rd(ADDR_MAX, 16'hFFFF);
        bus_rd(ADDR_STAT, 16'h0002);
        bus_rd(ADDR_CTRL, 16'h0000);
        bus_wr(ADDR_COUNT, 16'h1234);
        bus_rd(ADDR_COUNT, 16'h0000);
        bus_rd(4'hF, 16'h0000);
    endtask
    task automatic t_up();
        bus_wr(ADDR_CCR0, 16'h0001);
        bus_wr(ADDR_MAX, 16'h0002);
        bus_wr(ADDR_ENA, 16'h000F);
        bus_wr(ADDR_CTRL, 16'h0018);
        check({15'h0, running_status}, 16'h0001);
        bus_rd(ADDR_STAT, 16'h0003);
        bus_wr(ADDR_FLAG, 16'h000F);
        walk('{16'h0001, 16'h0002, 16'h0000, 16'h0001});
        bus_rd(ADDR_FLAG, 16'h000F);
        check({12'h0, evt_req}, 16'h000F);
        bus_wr(ADDR_ENA, 16'h0000);
        check({12'h0, evt_req}, 16'h0000);
        bus_wr(ADDR_FLAG, 16'h000F);
        bus_rd(ADDR_FLAG, 16'h0000);
        bus_wr(ADDR_CTRL, 16'h0000);
        bus_rd(ADDR_STAT, 16'h0002);
        walk('{16'h0001});
    endtask
    task automatic t_newmax();
        bus_wr(ADDR_MAX, 16'h0005);
        bus_wr(ADDR_CTRL, 16'h0018);
        walk('{16'h0001, 16'h0002, 16'h0003, 16'h0004});
        bus_wr(ADDR_MAX, 16'h0002);
        bus_rd(ADDR_CTRL, 16'h0030);
        walk('{16'h0000});
        bus_rd(ADDR_CTRL, 16'h0010);
        bus_wr(ADDR_MAX, 16'h0006);
        walk('{16'h0001, 16'h0002, 16'h0003});
    endtask
    task automatic t_down();
        bus_wr(ADDR_MAX, 16'h0003);
        bus_wr(ADDR_CTRL, 16'h0019);
        bus_rd(ADDR_COUNT, 16'h0003);
        bus_rd(ADDR_STAT, 16'h0001);
        bus_wr(ADDR_MAX, 16'h0001);
        walk('{16'h0002, 16'h0001, 16'h0000, 16'h0001});
    endtask
    task automatic t_updn();
        bus_wr(ADDR_MAX, 16'h0002);
        bus_wr(ADDR_CTRL, 16'h001A);
        walk('{16'h0001, 16'h0002, 16'h0001});
        bus_rd(ADDR_STAT, 16'h0001);
        bus_wr(ADDR_MAX, 16'h0003);
        walk('{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0002});
    endtask
    task automatic t_single();
        bus_wr(ADDR_MAX, 16'h0001);
        bus_wr(ADDR_CTRL, 16'h001C);
        walk('{16'h0001, 16'h0000, 16'h0000});
        bus_wr(ADDR_CTRL, 16'h001D);
        walk('{16'h0000, 16'h0001, 16'h0001});
        bus_wr(ADDR_MAX, 16'h0002);
        bus_wr(ADDR_CTRL, 16'h001E);
        walk('{16'h0001, 16'h0002, 16'h0001, 16'h0000, 16'h0000});
        check({15'h0, running_status}, 16'h0000);
    endtask
    task automatic t_buffer();
        bus_wr(ADDR_CCCTL0, 16'h0000);
        bus_wr(ADDR_CCR0, 16'h0002);
        bus_wr(ADDR_CCCTL0, 16'h0002);
        bus_wr(ADDR_CCR0, 16'h0001);
        bus_wr(ADDR_CCCTL1, 16'h0001);
        bus_wr(ADDR_CCR1, 16'h0001);
        bus_wr(ADDR_MAX, 16'h0003);
        bus_wr(ADDR_CTRL, 16'h0018);
        bus_wr(ADDR_FLAG, 16'h000F);
        step_match(2'b00);
        bus_rd(ADDR_COUNT, 16'h0001);
        bus_rd(ADDR_FLAG, 16'h0000);
        step_match(2'b01);
        bus_rd(ADDR_COUNT, 16'h0002);
        bus_rd(ADDR_FLAG, 16'h0004);
        bus_wr(ADDR_FLAG, 16'h000F);
        walk('{16'h0003, 16'h0000, 16'h0001});
        bus_rd(ADDR_FLAG, 16'h0007);
        bus_wr(ADDR_CCCTL0, 16'h0004);
        bus_wr(ADDR_CCR0, 16'h0000);
        bus_wr(ADDR_FLAG, 16'h000F);
        walk('{16'h0002, 16'h0003, 16'h0000});
        bus_rd(ADDR_FLAG, 16'h0007);
        bus_wr(ADDR_CCCTL0, 16'h0006);
        bus_wr(ADDR_CCR0, 16'h0002);
        bus_wr(ADDR_FLAG, 16'h000F);
        walk('{16'h0001, 16'h0002});
        bus_rd(ADDR_FLAG, 16'h0000);
        walk('{16'h0003, 16'h0000, 16'h0001, 16'h0002});
        bus_rd(ADDR_FLAG, 16'h0007);
        bus_wr(ADDR_CTRL, 16'h0013);
        bus_wr(ADDR_FLAG, 16'h000F);
        walk('{16'h0002});
        bus_rd(ADDR_FLAG, 16'h0000);
    endtask
    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial begin
        rst_n = 1'b0;
        count_clock = 1'b0;
        req = '0;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_up();
        t_newmax();
        t_down();
        t_updn();
        t_single();
        t_buffer();
        conclude();
    end
    initial begin
        #50000;
        fail_count++;
        conclude();
    end
endmodule
